// ---- logic/nvra_top.sv ----
// Nonvolatile memory access: pointer read path and APB register path
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
module nvra_top #(
  parameter logic [13:0] DEV_ID    = 14'h0a5a, // Arbitrary value
  parameter logic [13:0] REV_ID    = 14'h2001, // Arbitrary value
  parameter logic [13:0] USER_ROWS = 14'h0100,
  parameter logic [13:0] PIN_COUNT = 14'h001c,
  parameter logic [13:0] CFG_WORD  = 14'h3fff
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Indirect pointer path
  input  wire nvra_pkg::nvra_ptr_req_type ptr_req,
  output logic                            ptr_ready,
  output nvra_pkg::nvra_ptr_rsp_type      ptr_rsp,
  // Core and protection
  input  wire logic                       write_protect,
  output logic                            core_stall
);
  logic                     rst_meta;
  logic                     rst_n;
  nvra_pkg::nvra_state_type state;
  nvra_pkg::nvra_src_type   rd_src;
  nvra_pkg::nvra_src_type   ptr_src;
  logic                     rd_trig;
  logic                     wr_trig;
  logic                     wr_en;
  logic                     wr_err;
  logic                     latch_only;
  logic                     cfg_sel;
  logic [7:0]               addr_lo;
  logic [7:0]               addr_hi;
  logic [7:0]               data_lo;
  logic [5:0]               data_hi;
  logic [13:0]              cfg_hold;
  logic [7:0]               row_base;
  logic [5:0]               row_cnt;
  logic [13:0]              uid [0:3];
  logic [15:0]              addr_q;
  logic                     in_pfm;
  logic                     in_ee;
  logic                     in_uid;
  logic                     wr_ok;
  logic                     p_pfm;
  logic                     p_ee;
  logic                     idle;
  logic                     start_rd;
  logic                     start_wr;
  logic                     ptr_go;
  logic                     ee_wr;
  logic                     uid_wr;
  logic                     latch_wr;
  logic                     row_go;
  logic                     wr_fail;
  logic [13:0]              cfg_val;
  logic                     pfm_en;
  logic                     pfm_we;
  logic [12:0]              pfm_addr;
  logic [13:0]              pfm_rdata;
  logic                     ee_en;
  logic [7:0]               ee_addr;
  logic [7:0]               ee_rdata;
  logic                     lat_en;
  logic [4:0]               lat_addr;
  logic [13:0]              lat_rdata;
  logic [4:0]               row_idx;
  logic                     apb_setup;
  logic                     apb_wr;
  logic                     ctrl_free;
  logic [31:0]              next_prdata;
  logic                     next_pslverr;

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Region decode of the address pair and of the pointer address
  always_comb
  begin
    addr_q = {addr_hi, addr_lo};
    in_pfm = !cfg_sel && (addr_q <= nvra_pkg::PFM_LAST);
    in_ee  = !cfg_sel && (addr_q >= nvra_pkg::EE_FIRST) && (addr_q <= nvra_pkg::EE_LAST);
    in_uid = cfg_sel && (addr_q >= nvra_pkg::UID_FIRST) && (addr_q <= nvra_pkg::UID_LAST);
    // Only flash, EEPROM and user ID are writable
    wr_ok  = wr_en && !write_protect && (in_pfm || in_ee || in_uid);
    p_pfm  = ptr_req.addr <= nvra_pkg::PFM_LAST;
    p_ee   = (ptr_req.addr >= nvra_pkg::EE_FIRST) && (ptr_req.addr <= nvra_pkg::EE_LAST);
  end

  // Sequencing terms; the pointer path waits while a trigger is pending
  assign idle      = (state == nvra_pkg::ST_IDLE);
  assign start_rd  = idle && rd_trig;
  assign start_wr  = idle && wr_trig && !rd_trig;
  assign ptr_ready = idle && !rd_trig && !wr_trig;
  assign ptr_go    = ptr_ready && ptr_req.req && !ptr_req.we;
  assign ee_wr     = start_wr && wr_ok && in_ee;
  assign uid_wr    = start_wr && wr_ok && in_uid;
  assign latch_wr  = start_wr && wr_ok && in_pfm;
  assign row_go    = latch_wr && !latch_only;
  assign wr_fail   = start_wr && !wr_ok;
  assign core_stall = !idle;
  assign row_idx   = 5'(row_cnt - 6'h01);

  // Identification, configuration and fixed information words
  always_comb
  begin
    cfg_val = nvra_pkg::WORD_ZERO;
    if (in_uid)
    begin
      cfg_val = uid[addr_lo[1:0]];
    end
    else if (cfg_sel)
    begin
      if ((addr_q >= nvra_pkg::CFG_FIRST) && (addr_q <= nvra_pkg::CFG_LAST))
      begin
        cfg_val = CFG_WORD;
      end
      else if (addr_q == nvra_pkg::REV_ADDR)
      begin
        cfg_val = REV_ID;
      end
      else if (addr_q == nvra_pkg::DEV_ADDR)
      begin
        cfg_val = DEV_ID;
      end
      else if (addr_q == nvra_pkg::DCI_ERASE)
      begin
        cfg_val = nvra_pkg::ERASE_ROW_VAL;
      end
      else if (addr_q == nvra_pkg::DCI_LATCH)
      begin
        cfg_val = nvra_pkg::LATCH_VAL;
      end
      else if (addr_q == nvra_pkg::DCI_ROWS)
      begin
        cfg_val = USER_ROWS;
      end
      else if (addr_q == nvra_pkg::DCI_EESZ)
      begin
        cfg_val = nvra_pkg::EE_SIZE_VAL;
      end
      else if (addr_q == nvra_pkg::DCI_PINS)
      begin
        cfg_val = PIN_COUNT;
      end
    end
  end

  // Array port steering; row commit reads latch k while writing word k-1
  always_comb
  begin
    pfm_en   = 1'b0;
    pfm_we   = 1'b0;
    pfm_addr = ptr_req.addr[12:0];
    ee_en    = ptr_go && p_ee;
    ee_addr  = ptr_req.addr[7:0];
    lat_en   = latch_wr;
    lat_addr = addr_lo[4:0];
    if (state == nvra_pkg::ST_ROW)
    begin
      pfm_en   = (row_cnt != 6'h00) && !write_protect;
      pfm_we   = pfm_en;
      pfm_addr = {row_base, row_idx};
      lat_en   = (row_cnt != nvra_pkg::ROW_STEPS);
      lat_addr = row_cnt[4:0];
    end
    else if (start_rd)
    begin
      pfm_en   = in_pfm;
      pfm_addr = addr_q[12:0];
      ee_en    = in_ee;
      ee_addr  = addr_lo;
    end
    else if (ptr_go)
    begin
      pfm_en   = p_pfm;
    end
    if (ee_wr)
    begin
      ee_en   = 1'b1;
      ee_addr = addr_lo;
    end
  end

  // Program flash, 8K words
  nvra_mem #(.AW(nvra_pkg::PFM_AW), .DW(nvra_pkg::WORD_W)) u_pfm (
    .clk   (clk),
    .en    (pfm_en),
    .we    (pfm_we),
    .addr  (pfm_addr),
    .wdata (lat_rdata),
    .rdata (pfm_rdata)
  );

  // Data EEPROM, 256 bytes, written one byte at a time
  nvra_mem #(.AW(nvra_pkg::EE_AW), .DW(8)) u_eeprom (
    .clk   (clk),
    .en    (ee_en),
    .we    (ee_wr),
    .addr  (ee_addr),
    .wdata (data_lo),
    .rdata (ee_rdata)
  );

  // Row write latches
  nvra_mem #(.AW(nvra_pkg::LATCH_AW), .DW(nvra_pkg::WORD_W)) u_latch (
    .clk   (clk),
    .en    (lat_en),
    .we    (latch_wr),
    .addr  (lat_addr),
    .wdata ({data_hi, data_lo}),
    .rdata (lat_rdata)
  );

  // Access sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= nvra_pkg::ST_IDLE;
    end
    else
    begin
      unique case (state)
        nvra_pkg::ST_IDLE:
        begin
          if (start_rd)
          begin
            state <= nvra_pkg::ST_READ;
          end
          else if (row_go)
          begin
            state <= nvra_pkg::ST_ROW;
          end
          else if (ptr_go)
          begin
            state <= nvra_pkg::ST_PTR;
          end
        end
        nvra_pkg::ST_READ: state <= nvra_pkg::ST_IDLE;
        nvra_pkg::ST_ROW:
        begin
          if (row_cnt == nvra_pkg::ROW_STEPS)
          begin
            state <= nvra_pkg::ST_IDLE;
          end
        end
        nvra_pkg::ST_PTR: state <= nvra_pkg::ST_IDLE;
      endcase
    end
  end

  // Row commit counter and source tags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      row_cnt  <= 6'h00;
      row_base <= nvra_pkg::BYTE_RESET;
      rd_src   <= nvra_pkg::SRC_NONE;
      ptr_src  <= nvra_pkg::SRC_NONE;
      cfg_hold <= nvra_pkg::WORD_ZERO;
    end
    else
    begin
      if (row_go)
      begin
        row_cnt  <= 6'h00;
        row_base <= addr_q[12:5];
      end
      else if (state == nvra_pkg::ST_ROW)
      begin
        row_cnt <= 6'(row_cnt + 6'h01);
      end
      if (start_rd)
      begin
        rd_src   <= in_pfm ? nvra_pkg::SRC_PFM : in_ee ? nvra_pkg::SRC_EE
                  : cfg_sel ? nvra_pkg::SRC_CFG : nvra_pkg::SRC_NONE;
        cfg_hold <= cfg_val;
      end
      if (ptr_go)
      begin
        ptr_src <= p_pfm ? nvra_pkg::SRC_PFM : p_ee ? nvra_pkg::SRC_EE : nvra_pkg::SRC_NONE;
      end
    end
  end

  // User ID words, one per generate entry
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_uid
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          uid[gi] <= nvra_pkg::WORD_ZERO;
        end
        else if (uid_wr && (addr_lo[1:0] == 2'(gi)))
        begin
          uid[gi] <= {data_hi, data_lo};
        end
      end
    end
  endgenerate

  // Pointer answer: one byte, one cycle after the stall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_rsp <= '0;
    end
    else
    begin
      ptr_rsp.valid <= (state == nvra_pkg::ST_PTR);
      if (state == nvra_pkg::ST_PTR)
      begin
        unique case (ptr_src)
          nvra_pkg::SRC_PFM:  ptr_rsp.data <= pfm_rdata[7:0];
          nvra_pkg::SRC_EE:   ptr_rsp.data <= ee_rdata;
          nvra_pkg::SRC_CFG:  ptr_rsp.data <= nvra_pkg::BYTE_RESET;
          nvra_pkg::SRC_NONE: ptr_rsp.data <= nvra_pkg::BYTE_RESET;
        endcase
      end
    end
  end

  // APB phases; settings freeze while an operation is pending
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign pready    = psel && penable;
  assign ctrl_free = idle && !rd_trig && !wr_trig;

  // Control bits; hardware clears triggers, a failed write sets the error flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_trig    <= 1'b0;
      wr_trig    <= 1'b0;
      wr_en      <= 1'b0;
      wr_err     <= 1'b0;
      latch_only <= 1'b0;
      cfg_sel    <= 1'b0;
    end
    else
    begin
      if (apb_wr && (paddr == nvra_pkg::OFS_CTRL) && ctrl_free)
      begin
        rd_trig    <= pwdata[nvra_pkg::CTRL_RD];
        wr_trig    <= pwdata[nvra_pkg::CTRL_WR];
        wr_en      <= pwdata[nvra_pkg::CTRL_WREN];
        latch_only <= pwdata[nvra_pkg::CTRL_LATCH];
        cfg_sel    <= pwdata[nvra_pkg::CTRL_CFGSEL];
      end
      else
      begin
        if (state == nvra_pkg::ST_READ)
        begin
          rd_trig <= 1'b0;
        end
        if ((start_wr && !row_go) || ((state == nvra_pkg::ST_ROW)
            && (row_cnt == nvra_pkg::ROW_STEPS)))
        begin
          wr_trig <= 1'b0;
        end
      end
      // Hardware set wins over a software clear in the same cycle
      if (wr_fail)
      begin
        wr_err <= 1'b1;
      end
      else if (apb_wr && (paddr == nvra_pkg::OFS_CTRL) && !pwdata[nvra_pkg::CTRL_WRERR])
      begin
        wr_err <= 1'b0;
      end
    end
  end

  // Address pair, written only while no operation is pending
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_lo <= nvra_pkg::BYTE_RESET;
      addr_hi <= nvra_pkg::BYTE_RESET;
    end
    else if (apb_wr && ctrl_free)
    begin
      if (paddr == nvra_pkg::OFS_ADDR_LOW)
      begin
        addr_lo <= pwdata[7:0];
      end
      if (paddr == nvra_pkg::OFS_ADDR_HIGH)
      begin
        addr_hi <= pwdata[7:0];
      end
    end
  end

  // Data pair: a completing read wins over a software write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_lo <= nvra_pkg::BYTE_RESET;
      data_hi <= nvra_pkg::HIGH_RESET;
    end
    else if (state == nvra_pkg::ST_READ)
    begin
      unique case (rd_src)
        nvra_pkg::SRC_PFM:  {data_hi, data_lo} <= pfm_rdata;
        nvra_pkg::SRC_EE:   {data_hi, data_lo} <= {nvra_pkg::HIGH_RESET, ee_rdata};
        nvra_pkg::SRC_CFG:  {data_hi, data_lo} <= cfg_hold;
        nvra_pkg::SRC_NONE: {data_hi, data_lo} <= nvra_pkg::WORD_ZERO;
      endcase
    end
    else if (apb_wr && (paddr == nvra_pkg::OFS_DATA_LOW))
    begin
      data_lo <= pwdata[7:0];
    end
    else if (apb_wr && (paddr == nvra_pkg::OFS_DATA_HIGH))
    begin
      data_hi <= pwdata[5:0];
    end
  end

  // Read mux, sampled in the setup phase so read data leaves a flop
  always_comb
  begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    unique case (paddr)
      nvra_pkg::OFS_CTRL:
        next_prdata[7:0] = {1'b0, cfg_sel, latch_only, 1'b0, wr_err, wr_en, wr_trig, rd_trig};
      nvra_pkg::OFS_ADDR_LOW:  next_prdata[7:0] = addr_lo;
      nvra_pkg::OFS_ADDR_HIGH: next_prdata[7:0] = addr_hi;
      nvra_pkg::OFS_DATA_LOW:  next_prdata[7:0] = data_lo;
      nvra_pkg::OFS_DATA_HIGH: next_prdata[5:0] = data_hi;
      nvra_pkg::OFS_STATUS:    next_prdata[1:0] = {write_protect, core_stall};
      default:                 next_pslverr = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (apb_setup)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Checks
  AST_READ_STALL: assert property (@(posedge clk) disable iff (!rst_n)
    start_rd |=> core_stall ##1 !core_stall)
    else $error("read stall not exactly one cycle");

  AST_RD_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    start_rd |=> ##1 !rd_trig)
    else $error("read trigger not cleared after read");

  AST_DATA_NEXT: assert property (@(posedge clk) disable iff (!rst_n)
    (state == nvra_pkg::ST_READ && rd_src == nvra_pkg::SRC_PFM)
    |=> {data_hi, data_lo} == $past(pfm_rdata))
    else $error("read data not in data pair next cycle");

  AST_DATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (state != nvra_pkg::ST_READ && !apb_wr) |=> $stable(data_lo) && $stable(data_hi))
    else $error("data pair changed without read or write");

  AST_PTR_TIMING: assert property (@(posedge clk) disable iff (!rst_n)
    ptr_go |=> core_stall ##1 (!core_stall && ptr_rsp.valid))
    else $error("pointer read not one stall cycle");

  AST_PTR_NO_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (ptr_req.req && ptr_req.we && ptr_ready) |-> !ee_wr && !pfm_we && !uid_wr && !ptr_go)
    else $error("pointer write reached memory");

  AST_WP_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
    write_protect |-> !ee_wr && !pfm_we && !uid_wr && !latch_wr)
    else $error("write while protected");

  AST_LATCH_WORD: assert property (@(posedge clk) disable iff (!rst_n)
    (start_rd && cfg_sel && addr_q == nvra_pkg::DCI_LATCH)
    |=> ##1 {data_hi, data_lo} == 14'h0020)
    else $error("latch count word wrong");

  AST_ROW_END: assert property (@(posedge clk) disable iff (!rst_n)
    (state == nvra_pkg::ST_ROW && row_cnt == nvra_pkg::ROW_STEPS) |=> idle && !wr_trig)
    else $error("row commit did not end");

  AST_RO_REGION: assert property (@(posedge clk) disable iff (!rst_n)
    (start_wr && cfg_sel && !in_uid) |=> wr_err && !$past(uid_wr))
    else $error("write to read-only region not refused");
endmodule // nvra_top

// ---- logic/nvra_pkg.sv ----
// Package: constants, register map and carriers of the nonvolatile access block
//Contract
// - A 256-byte data EEPROM is reachable by pointer and registers.
// - EEPROM writes one byte at a time; program flash writes only whole rows.
// - A pointer read of program flash stalls the core one cycle, then resumes.
// - Each pointer read returns exactly one byte.
// - The pointer path never writes or erases; memory stays unchanged.
// - Register path writes pointer-reachable space and user ID; ID/config are read-only.
// - With write protection on, the register path blocks every write and erase.
// - The read trigger stalls the core for the access and releases it after.
// - Read data lands in the data pair on the very next cycle.
// - The data pair holds until another read or a software write.
// - Hardware clears the read trigger when the read completes.
// - Configuration-information region occupies 8200h to 821Fh, fixed at manufacture.
// - Configuration and device-information regions are read-only; writes only set the error flag.
// - Configuration word 8201h reports 32 write latches.
package nvra_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_ADDR_LOW  = 8'h04;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h08;
  localparam logic [7:0] OFS_DATA_LOW  = 8'h0c;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  // Control register bit positions
  localparam int CTRL_RD     = 0;
  localparam int CTRL_WR     = 1;
  localparam int CTRL_WREN   = 2;
  localparam int CTRL_WRERR  = 3;
  localparam int CTRL_LATCH  = 5;
  localparam int CTRL_CFGSEL = 6;
  // Reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [5:0] HIGH_RESET = 6'h00;
  // Array geometry
  localparam int PFM_AW   = 13;
  localparam int WORD_W   = 14;
  localparam int EE_AW    = 8;
  localparam int LATCH_AW = 5;
  localparam logic [5:0] ROW_STEPS = 6'h20;
  // Address map in the 16-bit space of the address pair
  localparam logic [15:0] PFM_LAST  = 16'h1fff;
  localparam logic [15:0] EE_FIRST  = 16'hf000;
  localparam logic [15:0] EE_LAST   = 16'hf0ff;
  localparam logic [15:0] UID_FIRST = 16'h8000;
  localparam logic [15:0] UID_LAST  = 16'h8003;
  localparam logic [15:0] REV_ADDR  = 16'h8005;
  localparam logic [15:0] DEV_ADDR  = 16'h8006;
  localparam logic [15:0] CFG_FIRST = 16'h8007;
  localparam logic [15:0] CFG_LAST  = 16'h800b;
  localparam logic [15:0] DCI_ERASE = 16'h8200;
  localparam logic [15:0] DCI_LATCH = 16'h8201;
  localparam logic [15:0] DCI_ROWS  = 16'h8202;
  localparam logic [15:0] DCI_EESZ  = 16'h8203;
  localparam logic [15:0] DCI_PINS  = 16'h8204;
  // Fixed contents of the configuration-information region
  localparam logic [13:0] ERASE_ROW_VAL = 14'h0020;
  localparam logic [13:0] LATCH_VAL     = 14'h0020;
  localparam logic [13:0] EE_SIZE_VAL   = 14'h0100;
  localparam logic [13:0] WORD_ZERO     = 14'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_ROW  = 2'b10,
    ST_PTR  = 2'b11
  } nvra_state_type;

  typedef enum logic [1:0] {
    SRC_PFM  = 2'b00,
    SRC_EE   = 2'b01,
    SRC_CFG  = 2'b10,
    SRC_NONE = 2'b11
  } nvra_src_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
  } nvra_ptr_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } nvra_ptr_rsp_type;
endpackage

// ---- logic/nvra_mem.sv ----
// Single-port array with registered read data
`timescale 1ns/1ps
module nvra_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          clk,
  // Access port
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] store [0:(1<<AW)-1];

  // Contents are not reset; a real array keeps them across reset anyway
  always_ff @(posedge clk)
  begin
    if (en && we)
    begin
      store[addr] <= wdata;
    end
    else if (en)
    begin
      rdata <= store[addr];
    end
  end
endmodule // nvra_mem

// ---- dv/nvra_core_model.sv ----
// Core-side model: pointer reads and stall counting
`timescale 1ns/1ps
module nvra_core_model (
  // Clock
  input  wire logic                       clk,
  // Pointer path
  output nvra_pkg::nvra_ptr_req_type      ptr_req,
  input  wire logic                       ptr_ready,
  input  wire nvra_pkg::nvra_ptr_rsp_type ptr_rsp,
  input  wire logic                       core_stall
);
  initial ptr_req = '0;

  // Request held until taken; released lines show inverted values
  task automatic access(input logic [15:0] a, input logic w,
                        output logic [7:0] d, output int st);
    st = 0;
    d = 8'h00;
    @(posedge clk);
    ptr_req <= '{req: 1'b1, we: w, addr: a};
    do @(posedge clk); while (ptr_ready !== 1'b1);
    ptr_req <= '{req: 1'b0, we: ~w, addr: ~a};
    if (!w)
    begin
      #1;
      // Core sits stalled until the byte arrives
      while (ptr_rsp.valid !== 1'b1)
      begin
        st += int'(core_stall);
        @(posedge clk);
        #1;
      end
      d = ptr_rsp.data;
    end
  endtask
endmodule // nvra_core_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the nonvolatile access block
`timescale 1ns/1ps
module tb_top;
  logic                       clk = 1'b0;
  logic                       reset_n = 1'b0;
  logic                       psel = 1'b0;
  logic                       penable = 1'b0;
  logic                       pwrite = 1'b0;
  logic [7:0]                 paddr = 8'h00;
  logic [31:0]                pwdata = 32'h0;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  nvra_pkg::nvra_ptr_req_type ptr_req;
  logic                       ptr_ready;
  nvra_pkg::nvra_ptr_rsp_type ptr_rsp;
  logic                       write_protect = 1'b0;
  logic                       core_stall;
  logic [31:0]                seed = 32'hcc65ea28;
  logic [31:0]                rv;
  logic                       ev;
  logic                       lo = 1'b0;
  logic [13:0]                wv;
  logic [31:0]                r;
  logic [15:0]                a;
  logic [7:0]                 b;
  int                         st;
  int                         miscompares = 0;
  int                         num_checks = 0;
  int                         cyc = 0;
  int                         ee [256];
  logic [15:0]                cfg_a [4] = '{16'h8200, 16'h8201, 16'h8202, 16'h8203};
  int                         cfg_e [4] = '{32, 32, 256, 256};

  nvra_top u_nvra_top (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ptr_req, .ptr_ready, .ptr_rsp, .write_protect,
    .core_stall);
  nvra_core_model u_nvra_core_model (.clk, .ptr_req, .ptr_ready, .ptr_rsp,
    .core_stall);

  always #25 clk = ~clk;

  // Hang guard, far above the expected run length
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      miscompares++;
      stop_test();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask

  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic setad(input logic [15:0] x);
    apb(1'b1, nvra_pkg::OFS_ADDR_LOW, {24'h0, x[7:0]});
    apb(1'b1, nvra_pkg::OFS_ADDR_HIGH, {24'h0, x[15:8]});
  endtask

  task automatic rdmem(input logic [15:0] x, input logic s);
    setad(x);
    apb(1'b1, nvra_pkg::OFS_CTRL, {25'h0, s, 6'h01});
    do apb(1'b0, nvra_pkg::OFS_CTRL, 32'h0); while (rv[0] !== 1'b0);
    apb(1'b0, nvra_pkg::OFS_DATA_HIGH, 32'h0);
    wv[13:8] = rv[5:0];
    apb(1'b0, nvra_pkg::OFS_DATA_LOW, 32'h0);
    wv[7:0] = rv[7:0];
  endtask

  // Write enable first, then the trigger; a zero latch bit commits a row
  task automatic wrmem(input logic [15:0] x, input logic s, input logic [13:0] d);
    setad(x);
    apb(1'b1, nvra_pkg::OFS_DATA_LOW, {24'h0, d[7:0]});
    apb(1'b1, nvra_pkg::OFS_DATA_HIGH, {26'h0, d[13:8]});
    apb(1'b1, nvra_pkg::OFS_CTRL, {25'h0, s, lo, 5'h04});
    apb(1'b1, nvra_pkg::OFS_CTRL, {25'h0, s, lo, 5'h06});
    do apb(1'b0, nvra_pkg::OFS_CTRL, 32'h0); while (rv[1] !== 1'b0);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, nvra_pkg::OFS_CTRL, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, nvra_pkg::OFS_STATUS, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, ev}, 32'h1);
    $display("test reset done");
    // Random EEPROM bytes, flash words and user ID words
    repeat (4)
    begin
      r = xs();
      a = {8'hf0, r[7:0]};
      ee[r[7:0]] = int'(r[15:8]);
      wrmem(a, 1'b0, {6'h0, r[15:8]});
      rdmem(a, 1'b0);
      chk(wv, ee[a[7:0]]);
      u_nvra_core_model.access(a, 1'b0, b, st);
      chk(b, ee[a[7:0]]);
      chk(st, 1);
      u_nvra_core_model.access(a, 1'b1, b, st);
      u_nvra_core_model.access(a, 1'b0, b, st);
      chk(b, ee[a[7:0]]);
      a = {3'h0, r[28:16]};
      // Neighbour word only latched, then committed with the row
      lo = 1'b1;
      wrmem(a ^ 16'h0001, 1'b0, r[17:4]);
      lo = 1'b0;
      wrmem(a, 1'b0, r[31:18]);
      rdmem(a, 1'b0);
      chk(wv, r[31:18]);
      rdmem(a ^ 16'h0001, 1'b0);
      chk(wv, r[17:4]);
      u_nvra_core_model.access(a, 1'b0, b, st);
      chk(b, r[25:18]);
      wrmem({14'h2000, r[1:0]}, 1'b1, r[13:0]);
      rdmem({14'h2000, r[1:0]}, 1'b1);
      chk(wv, r[13:0]);
    end
    $display("test access done");
    // Protected write to the last-written EEPROM byte is blocked
    write_protect <= 1'b1;
    apb(1'b0, nvra_pkg::OFS_STATUS, 32'h0);
    chk(rv[1], 1'b1);
    wrmem(a, 1'b0, 14'h0000);
    wrmem({8'hf0, r[7:0]}, 1'b0, {6'h0, ~r[15:8]});
    chk(rv[3], 1'b1);
    rdmem({8'hf0, r[7:0]}, 1'b0);
    chk(wv, ee[r[7:0]]);
    write_protect <= 1'b0;
    apb(1'b1, nvra_pkg::OFS_CTRL, 32'h0);
    $display("test protect done");
    // Fixed information words, and a write that must not land
    foreach (cfg_a[i])
    begin
      rdmem(cfg_a[i], 1'b1);
      chk(wv, cfg_e[i]);
    end
    wrmem(16'h8201, 1'b1, 14'h0000);
    chk(rv[3], 1'b1);
    rdmem(16'h8201, 1'b1);
    chk(wv, 32'd32);
    // Data pair holds a software write
    apb(1'b1, nvra_pkg::OFS_DATA_LOW, 32'h5a);
    apb(1'b0, nvra_pkg::OFS_STATUS, 32'h0);
    apb(1'b0, nvra_pkg::OFS_DATA_LOW, 32'h0);
    chk(rv, 32'h5a);
    $display("test info done");
    stop_test();
  end
endmodule // tb_top
